// ### hw/ecdiag_core.sv
// Encoder link circuit diagnosis controller
`timescale 1ns/10ps
`include "ecdiag_defs.svh"
module ecdiag_core #(
  parameter int BIT_CYCLES = `ECDIAG_BIT_CYCLES
) (
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    variant_analog_in,
  input  wire logic                    encoder_quad_index_in,
  input  wire logic                    encoder_diag_enable_field_net_in,
  input  wire logic                    encoder_diag_enable_field_analog_in,
  input  wire logic                    norm_tx_data_in,
  input  wire logic                    norm_tx_en_in,
  input  wire logic                    link_rx_in,
  output ecdiag_pkg::ecdiag_drv_t      link_drv_out,
  output logic                         norm_rx_out,
  output ecdiag_pkg::ecdiag_alarm_t    encoder_diag_in_progress_alarm_out,
  output logic                         diag_fault_out,
  output logic                         diag_unsupported_out,
  output logic                         diag_done_out
);
  import ecdiag_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic field_on(input logic field);
    return (field == `ECDIAG_FIELD_ENABLE);
  endfunction

  function automatic logic [3:0] sat_inc4(input logic [3:0] val);
    return (val == 4'hF) ? val : val + 4'h1;
  endfunction

  // ==========================================================
  // Power-up capture
  ecdiag_state_t state;
  ecdiag_state_t next_state;
  logic          captured;

  wire net_on     = field_on(encoder_diag_enable_field_net_in);
  wire analog_on  = field_on(encoder_diag_enable_field_analog_in);
  wire sel_enable = variant_analog_in ? analog_on : net_on;
  wire quad_enc   = encoder_quad_index_in;

  always_comb begin
    next_state = state;
    unique case (state)
      ECDIAG_ST_IDLE: begin
        if (!sel_enable) begin
          next_state = ECDIAG_ST_NORMAL;
        end else if (quad_enc) begin
          next_state = ECDIAG_ST_BLOCK;
        end else begin
          next_state = ECDIAG_ST_DIAG;
        end
      end
      ECDIAG_ST_NORMAL: next_state = ECDIAG_ST_NORMAL;
      ECDIAG_ST_DIAG:   next_state = ECDIAG_ST_DIAG;
      ECDIAG_ST_BLOCK:  next_state = ECDIAG_ST_BLOCK;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= ECDIAG_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      captured <= 1'b0;
    end else begin
      captured <= 1'b1;
    end
  end

  // ==========================================================
  // Mode decode
  wire in_normal = (state == ECDIAG_ST_NORMAL);
  wire diag_mode = (state == ECDIAG_ST_DIAG);
  wire in_block  = (state == ECDIAG_ST_BLOCK);
  wire next_diag = (next_state == ECDIAG_ST_DIAG);

  // ==========================================================
  // Stimulus timing
  logic [15:0] bit_cnt;
  logic [15:0] next_bit_cnt;
  logic        stim_bit;

  wire bit_end = diag_mode && (bit_cnt == 16'(BIT_CYCLES - 1));

  assign next_bit_cnt = (!diag_mode || bit_end) ? 16'h0000
                                                : bit_cnt + 16'h0001;

  ecdiag_pattern u_pattern (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .step_in (bit_end),
    .bit_out (stim_bit)
  );

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      bit_cnt <= 16'h0000;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // ==========================================================
  // Response check
  logic [3:0] miss_cnt;
  logic [3:0] next_miss_cnt;
  logic [7:0] check_cnt;
  logic [7:0] next_check_cnt;
  logic       rx_q;
  logic       fault;
  logic       next_fault;
  logic       done;
  logic       next_done;

  wire live     = bit_end && !done;
  wire mismatch = live && (rx_q != stim_bit);
  wire last_chk = bit_end && (check_cnt == 8'hFF);
  wire at_limit = (miss_cnt >= `ECDIAG_FAIL_LIMIT);

  assign next_check_cnt = live ? check_cnt + 8'h01 : check_cnt;
  assign next_miss_cnt  = mismatch ? sat_inc4(miss_cnt) : miss_cnt;
  assign next_fault     = fault || (mismatch && at_limit);
  assign next_done      = done || last_chk;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_q <= 1'b0;
    end else begin
      rx_q <= link_rx_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      miss_cnt  <= 4'h0;
      check_cnt <= 8'h00;
    end else begin
      miss_cnt  <= next_miss_cnt;
      check_cnt <= next_check_cnt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fault <= 1'b0;
      done  <= 1'b0;
    end else begin
      fault <= next_fault;
      done  <= next_done;
    end
  end

  // ==========================================================
  // Link driver and receiver path
  ecdiag_drv_t   next_drv;
  ecdiag_drv_t   drv;
  logic          next_rx_out;
  logic          rx_out;

  always_comb begin
    if (diag_mode) begin
      next_drv.tx_data = stim_bit;
      next_drv.tx_en   = 1'b1;
    end else if (in_normal) begin
      next_drv.tx_data = norm_tx_data_in;
      next_drv.tx_en   = norm_tx_en_in;
    end else begin
      next_drv.tx_data = 1'b0;
      next_drv.tx_en   = 1'b0;
    end
  end

  assign next_rx_out = in_normal ? link_rx_in : 1'b0;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      drv <= '0;
    end else begin
      drv <= next_drv;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_out <= 1'b0;
    end else begin
      rx_out <= next_rx_out;
    end
  end

  // ==========================================================
  // Alarm
  ecdiag_alarm_t next_alarm;
  ecdiag_alarm_t alarm;

  assign next_alarm = {next_diag,
                       `ECDIAG_ALARM_MAJOR,
                       `ECDIAG_ALARM_MINOR};

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      alarm <= '0;
    end else begin
      alarm <= next_alarm;
    end
  end

  // ==========================================================
  // Outputs
  assign link_drv_out                       = drv;
  assign norm_rx_out                        = rx_out;
  assign encoder_diag_in_progress_alarm_out = alarm;
  assign diag_fault_out                     = fault;
  assign diag_done_out                      = done;
  assign diag_unsupported_out               = captured && in_block;
endmodule

// ### common/ecdiag_defs.svh
// Constants for the encoder link circuit diagnosis block
// Contract
// - In diagnosis mode, drive stimulus into own link; flag link faults.
// - No diagnosis for quadrature encoders with an index channel.
// - Mode field sampled at power-up only; later writes wait for power cycle.
// - Diagnosis-in-progress alarm held for the whole diagnosis mode.
// - Field value 0 disables, 1 enables; factory value is 0.
// - Analog/pulse variants use their own enable field, same behaviour.
`ifndef ECDIAG_DEFS_SVH
`define ECDIAG_DEFS_SVH
`define ECDIAG_FIELD_DISABLE 1'h0
`define ECDIAG_FIELD_ENABLE  1'h1
`define ECDIAG_FIELD_INIT    1'h0
`define ECDIAG_ALARM_MAJOR   8'h76
`define ECDIAG_ALARM_MINOR   4'h1
`define ECDIAG_PATTERN_SEED  8'h5A
`define ECDIAG_PERIOD_NS     1000
`define ECDIAG_CLK_NS        4
`define ECDIAG_BIT_CYCLES    (`ECDIAG_PERIOD_NS / `ECDIAG_CLK_NS)
`define ECDIAG_FAIL_LIMIT    4'h3
`endif

// ### common/ecdiag_pkg.sv
// Types of the encoder link circuit diagnosis block
package ecdiag_pkg;
  typedef enum logic [1:0] {
    ECDIAG_ST_IDLE   = 2'b00,
    ECDIAG_ST_NORMAL = 2'b01,
    ECDIAG_ST_DIAG   = 2'b10,
    ECDIAG_ST_BLOCK  = 2'b11
  } ecdiag_state_t;

  typedef struct packed {
    logic tx_data;
    logic tx_en;
  } ecdiag_drv_t;

  typedef struct packed {
    logic       active;
    logic [7:0] code_major;
    logic [3:0] code_minor;
  } ecdiag_alarm_t;
endpackage

// ### hw/ecdiag_pattern.sv
// Pseudo-random stimulus generator for the loop check
`timescale 1ns/10ps
`include "ecdiag_defs.svh"
module ecdiag_pattern (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       step_in,
  output logic            bit_out
);
  logic [7:0] lfsr;
  wire        fb = lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3];

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lfsr <= `ECDIAG_PATTERN_SEED;
    end else if (step_in) begin
      lfsr <= {lfsr[6:0], fb};
    end
  end

  assign bit_out = lfsr[7];
endmodule

// ### verif/ecdiag_enc_model.sv
// Loopback partner standing in for the encoder link wiring
`timescale 1ns/10ps
module ecdiag_enc_model (
  input  wire logic                    clk_in,
  input  wire ecdiag_pkg::ecdiag_drv_t drv_in,
  input  wire logic                    brk_in,
  output logic                         rx_out
);
  import ecdiag_pkg::*;
  logic tgl = 1'b0;
  // Released line wanders
  always @(posedge clk_in) tgl <= ~tgl;
  assign rx_out = drv_in.tx_en ? drv_in.tx_data ^ brk_in : tgl;
endmodule

// ### verif/ecdiag_checker.sv
// Assertions on the encoder link diagnosis controller
`timescale 1ns/10ps
module ecdiag_checker (
  input wire logic                      clk_in,
  input wire logic                      nrst_in,
  input wire logic                      variant_analog_in,
  input wire logic                      encoder_quad_index_in,
  input wire logic                      encoder_diag_enable_field_net_in,
  input wire logic                      encoder_diag_enable_field_analog_in,
  input wire ecdiag_pkg::ecdiag_drv_t   link_drv_out,
  input wire logic                      norm_rx_out,
  input wire ecdiag_pkg::ecdiag_alarm_t encoder_diag_in_progress_alarm_out,
  input wire logic                      diag_fault_out,
  input wire logic                      diag_unsupported_out
);
  import ecdiag_pkg::*;
  logic [1:0] up;
  wire act = encoder_diag_in_progress_alarm_out.active;
  wire en = variant_analog_in ? encoder_diag_enable_field_analog_in
                              : encoder_diag_enable_field_net_in;
  wire st = nrst_in && up == 2'h0;
  wire qd = encoder_quad_index_in;
  always_ff @(posedge clk_in)
    up <= !nrst_in ? 2'h0 : up + {1'b0, up != 2'h3};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_start; st |-> ##[1:2] act == (en && !qd); endproperty
  a_start: assert property (p_start) else $error("bad mode");
  property p_quad; st && qd && en |=> !act ##1 !act && diag_unsupported_out;
  endproperty
  a_quad: assert property (p_quad) else $error("quad refused");
  property p_frozen; up == 2'h3 |-> $stable(act); endproperty
  a_frozen: assert property (p_frozen) else $error("mode moved");
  property p_code; act |-> encoder_diag_in_progress_alarm_out.code_major
    == 8'h76 && encoder_diag_in_progress_alarm_out.code_minor == 4'h1;
  endproperty
  a_code: assert property (p_code) else $error("alarm code");
  property p_drive; $past(act, 2) && act |-> link_drv_out.tx_en;
  endproperty
  a_drive: assert property (p_drive) else $error("no stimulus");
  property p_fault; diag_fault_out |-> act; endproperty
  a_fault: assert property (p_fault) else $error("stray fault");
  property p_rx; $past(act) && act |-> !norm_rx_out; endproperty
  a_rx: assert property (p_rx) else $error("rx leaked");
  cover property (st && en && !qd);
  cover property (diag_fault_out);
  cover property (diag_unsupported_out);
endmodule
bind ecdiag_core ecdiag_checker u_chk (.*);

// ### verif/tb_top.sv
// Testbench for the encoder link diagnosis controller
`timescale 1ns/10ps
module tb_top;
  import ecdiag_pkg::*;
  logic          clk_in = 1'b0;
  logic          nrst_in = 1'b0;
  logic          brk = 1'b0;
  logic          ntx = 1'b1;
  logic [3:0]    cfg = 4'h0;
  ecdiag_drv_t   drv;
  ecdiag_alarm_t alm;
  logic          rx, nrx, flt, uns, dn;
  int            miscompares = 0;
  int            tests_run = 0;
  // Variant, quad, net, analog, alarm, unsupported
  logic [5:0] rows [6] = '{6'h04, 6'h0A, 6'h28, 6'h26, 6'h19, 6'h10};
  initial forever #2 clk_in = ~clk_in;
  ecdiag_core #(.BIT_CYCLES(4)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .variant_analog_in(cfg[3]), .encoder_quad_index_in(cfg[2]),
    .encoder_diag_enable_field_net_in(cfg[1]),
    .encoder_diag_enable_field_analog_in(cfg[0]),
    .norm_tx_data_in(ntx), .norm_tx_en_in(1'b1), .link_rx_in(rx),
    .link_drv_out(drv), .norm_rx_out(nrx),
    .encoder_diag_in_progress_alarm_out(alm), .diag_fault_out(flt),
    .diag_unsupported_out(uns), .diag_done_out(dn));
  ecdiag_enc_model enc (.clk_in(clk_in), .drv_in(drv), .brk_in(brk),
    .rx_out(rx));
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task boot(input logic [3:0] c, input logic b);
    @(negedge clk_in);
    nrst_in = 1'b0;
    cfg = c;
    brk = b;
    repeat (5) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask
  initial begin
    foreach (rows[i]) begin
      boot(rows[i][5:2], 1'b0);
      chk(alm.active, rows[i][1]);
      chk(uns, rows[i][0]);
      chk(drv.tx_en, !rows[i][0]);
      chk(nrx, !rows[i][1] && !rows[i][0]);
      if (rows[i][1]) chk(alm.code_major, 8'h76);
      if (rows[i][1]) chk(alm.code_minor, 8'h01);
      if (!rows[i][1]) chk(drv.tx_data, !rows[i][0]);
      ntx = 1'b0;
      @(negedge clk_in);
      if (!rows[i][1]) chk(drv.tx_data, 1'b0);
      @(negedge clk_in);
      chk(nrx, 1'b0);
      ntx = 1'b1;
      cfg[1:0] = ~cfg[1:0];
      repeat (1100) @(negedge clk_in);
      chk(alm.active, rows[i][1]);
      chk(dn, rows[i][1]);
      chk(flt, 1'b0);
    end
    boot(4'h2, 1'b1);
    repeat (1100) @(negedge clk_in);
    chk(flt, 1'b1);
    chk(dn, 1'b1);
    chk(alm.active, 1'b1);
    complete_run;
  end
  initial begin
    #100000;
    miscompares++;
    complete_run;
  end
endmodule
